// File: hw/cpsm_monitor.sv
// Crank and cam pickup signal monitor with per-input diagnostic flags.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R1 - A period shorter than the previous one shifted right by short_shift sets the faulty-signal flag with report.
// R2 - A period that, shifted right by long_shift, exceeds the previous one sets the missing-signal flag with report.
// R3 - When no edge arrives within the timeout, the timeout flag is set and the count so far is reported.
// R4 - At each index mark while synced the counted events are compared with the expected value and a mismatch is flagged.
// R5 - A pulse whose high time exceeds its low time inverts the input internally and sets an info flag.
// R6 - When high and low times are equal or the input times out during polarity detection, polarity detection failed is flagged.
// R7 - Self test starts only when all inputs are at standstill and aborts on any pickup activity.
// R8 - A self test abort flags the input that showed pulses and reports its number.
// R9 - When the count of a synced input runs one past the expected value without index, index mark missing is flagged.
// R10 - When the index search runs two revolutions without an index, no index found is flagged.
// R11 - When a synced input sees two revolutions without index, missing index is flagged and sync drops.
// R12 - A timeout with no events counted at all flags no signal.
// R13 - An index mark at the wrong count while synced flags a synchronization error and resynchronizes.
// R14 - An event counter overflow flags an operational error on that input.
// R15 - An index arriving before the expected count is reached flags a faulty index.
// R16 - Every event latches a per-input flag that stays set until its clear bit is raised; set wins.
////////////////////////////////////////////////////////////////////////////////
module cpsm_monitor
	import cpsm_pkg::*;
#(
	parameter int NUM_INPUTS = 2,
	parameter int IDX_W = 1
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [NUM_INPUTS-1:0] engine_position_input,
	input wire logic [NUM_INPUTS-1:0] index_mark,
	input wire cpsm_cfg_s cfg,
	input wire logic [NUM_INPUTS-1:0][CPSM_EV_W-1:0] flag_clear,
	input wire logic self_test_req,
	output logic [NUM_INPUTS-1:0][CPSM_EV_W-1:0] event_flags,
	output cpsm_rpt_s [NUM_INPUTS-1:0] event_report,
	output logic [NUM_INPUTS-1:0] polarity_inverted,
	output logic [NUM_INPUTS-1:0] synced,
	output logic self_test_active,
	output logic self_test_aborted,
	output logic [IDX_W-1:0] abort_input
);
	typedef struct packed {
		cpsm_ch_e [NUM_INPUTS-1:0] ch;
		logic [NUM_INPUTS-1:0] invert;
		logic [NUM_INPUTS-1:0] prev_lvl;
		logic [NUM_INPUTS-1:0] prev_raw;
		logic [NUM_INPUTS-1:0] prev_idx;
		logic [NUM_INPUTS-1:0] seen_rise;
		logic [NUM_INPUTS-1:0] seen_fall;
		logic [NUM_INPUTS-1:0] active;
		logic [NUM_INPUTS-1:0][CPSM_PER_W-1:0] per_cnt;
		logic [NUM_INPUTS-1:0][CPSM_PER_W-1:0] last_per;
		logic [NUM_INPUTS-1:0][CPSM_PER_W-1:0] hi_time;
		logic [NUM_INPUTS-1:0][CPSM_CNT_W-1:0] ev_cnt;
		logic [NUM_INPUTS-1:0][CPSM_EV_W-1:0] flags;
		cpsm_rpt_s [NUM_INPUTS-1:0] rpt;
		cpsm_st_e st;
		logic [IDX_W-1:0] abort_idx;
	} cpsm_state_s;

	cpsm_state_s s;
	cpsm_state_s next_s;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic lvl;
		logic rise;
		logic fall;
		logic idx_e;
		logic raw_e;
		logic any_raw;
		logic count_on;
		logic [CPSM_EV_W-1:0] ev;
		logic [CPSM_PER_W-1:0] per;
		logic [CPSM_CNT_W:0] cnt_w;
		logic [CPSM_CNT_W:0] exp_w;
		lvl = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		idx_e = 1'b0;
		raw_e = 1'b0;
		any_raw = 1'b0;
		count_on = 1'b0;
		ev = CPSM_RST_FLAGS;
		per = CPSM_RST_PER;
		cnt_w = '0;
		exp_w = {1'b0, cfg.expected};
		next_s = s;
		for (int i = 0; i < NUM_INPUTS; i++) begin
			ev = CPSM_RST_FLAGS;
			lvl = engine_position_input[i] ^ s.invert[i];
			rise = lvl & ~s.prev_lvl[i];
			fall = ~lvl & s.prev_lvl[i];
			raw_e = engine_position_input[i] ^ s.prev_raw[i];
			idx_e = index_mark[i] & ~s.prev_idx[i];
			any_raw = any_raw | raw_e;
			per = s.per_cnt[i];
			next_s.prev_lvl[i] = lvl;
			next_s.prev_raw[i] = engine_position_input[i];
			next_s.prev_idx[i] = index_mark[i];
			// The period counter holds at the timeout so the timeout fires once per stall.
			// A zero timeout lets it run to full scale, so periods are still measured with the check off.
			if (cfg.timeout == CPSM_RST_PER) begin
				count_on = s.per_cnt[i] != {CPSM_PER_W{1'b1}};
			end else begin
				count_on = s.per_cnt[i] < cfg.timeout;
			end
			if (count_on) begin
				next_s.per_cnt[i] = s.per_cnt[i] + 24'h000001;
				if (next_s.per_cnt[i] == cfg.timeout && !(rise || fall)) begin
					ev[CPSM_EV_TIMEOUT] = 1'b1; // R3
					ev[CPSM_EV_NO_SIGNAL] = (s.ev_cnt[i] == CPSM_RST_CNT); // R12
					next_s.active[i] = 1'b0;
					if (s.ch[i] == CPSM_CH_POLARITY) begin
						ev[CPSM_EV_POL_FAIL] = 1'b1; // R6
						next_s.seen_rise[i] = 1'b0;
						next_s.seen_fall[i] = 1'b0;
					end
				end
			end
			if (raw_e) begin
				next_s.active[i] = 1'b1;
			end
			unique case (s.ch[i])
				CPSM_CH_POLARITY: begin
					// High and low times are measured on one whole pulse before trusting the level.
					if (fall && s.seen_rise[i]) begin
						next_s.hi_time[i] = per;
						next_s.seen_fall[i] = 1'b1;
					end
					if (rise || fall) begin
						next_s.per_cnt[i] = CPSM_RST_PER;
					end
					if (rise) begin
						next_s.seen_rise[i] = 1'b1;
						if (s.seen_fall[i]) begin
							if (s.hi_time[i] > per) begin
								next_s.invert[i] = ~s.invert[i]; // R5
								next_s.prev_lvl[i] = 1'b0; // R5
								ev[CPSM_EV_POL_REV] = 1'b1; // R5
								next_s.ch[i] = CPSM_CH_SEARCH;
							end else if (s.hi_time[i] < per) begin
								next_s.ch[i] = CPSM_CH_SEARCH;
							end else begin
								ev[CPSM_EV_POL_FAIL] = 1'b1; // R6
								next_s.seen_fall[i] = 1'b0;
							end
							next_s.last_per[i] = CPSM_RST_PER;
							next_s.ev_cnt[i] = CPSM_RST_CNT;
						end
					end
				end
				CPSM_CH_SEARCH, CPSM_CH_SYNCED: begin
					if (rise) begin
						next_s.per_cnt[i] = CPSM_RST_PER;
						next_s.last_per[i] = per;
						if (s.last_per[i] != CPSM_RST_PER) begin
							ev[CPSM_EV_FAULTY] = per < (s.last_per[i] >> cfg.short_shift); // R1
							ev[CPSM_EV_LONG] = (per >> cfg.long_shift) > s.last_per[i]; // R2
						end
						if (s.ev_cnt[i] == CPSM_CNT_MAX) begin
							ev[CPSM_EV_OPER_ERR] = 1'b1; // R14
						end else begin
							next_s.ev_cnt[i] = s.ev_cnt[i] + 12'h001;
						end
					end
					cnt_w = {1'b0, next_s.ev_cnt[i]};
					if (idx_e) begin
						next_s.ev_cnt[i] = CPSM_RST_CNT;
						next_s.ch[i] = CPSM_CH_SYNCED;
						if (s.ch[i] == CPSM_CH_SYNCED && cnt_w != exp_w) begin
							ev[CPSM_EV_MISMATCH] = 1'b1; // R4
							ev[CPSM_EV_FAULTY_INDEX] = cnt_w < exp_w; // R15
							ev[CPSM_EV_SYNC_ERR] = 1'b1; // R13
							next_s.ch[i] = CPSM_CH_SEARCH; // R13
						end
					end else if (rise && s.ch[i] == CPSM_CH_SYNCED) begin
						if (cnt_w == exp_w + 13'h0001) begin
							ev[CPSM_EV_MARK_MISSING] = 1'b1; // R9
						end
						if (cnt_w == {exp_w[CPSM_CNT_W-1:0], 1'b0}) begin
							ev[CPSM_EV_MISSING_INDEX] = 1'b1; // R11
							next_s.ch[i] = CPSM_CH_SEARCH; // R11
							next_s.ev_cnt[i] = CPSM_RST_CNT;
						end
					end else if (rise && cnt_w == {exp_w[CPSM_CNT_W-1:0], 1'b0}) begin
						ev[CPSM_EV_NO_INDEX] = 1'b1; // R10
						next_s.ev_cnt[i] = CPSM_RST_CNT;
					end
				end
				default: begin
					next_s.ch[i] = CPSM_CH_POLARITY;
				end
			endcase
			if (s.st == CPSM_ST_RUN && raw_e) begin
				ev[CPSM_EV_ST_ABORT] = 1'b1; // R8
				next_s.abort_idx = IDX_W'(i); // R8
			end
			// A report is only captured with an event, so it always describes the latest flag.
			if (ev != CPSM_RST_FLAGS) begin
				next_s.rpt[i].period = per;
				next_s.rpt[i].prev_period = s.last_per[i];
				next_s.rpt[i].count = s.ev_cnt[i];
				next_s.rpt[i].expected = cfg.expected;
			end
			next_s.flags[i] = (s.flags[i] & ~flag_clear[i]) | ev; // R16
		end
		unique case (s.st)
			CPSM_ST_IDLE: begin
				if (self_test_req && s.active == '0 && !any_raw) begin
					next_s.st = CPSM_ST_RUN; // R7
				end
			end
			CPSM_ST_RUN: begin
				if (any_raw) begin
					next_s.st = CPSM_ST_ABORT; // R7
				end else if (!self_test_req) begin
					next_s.st = CPSM_ST_IDLE;
				end
			end
			CPSM_ST_ABORT: begin
				// An aborted test must be withdrawn before another may start.
				if (!self_test_req) begin
					next_s.st = CPSM_ST_IDLE;
				end
			end
			default: begin
				next_s.st = CPSM_ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			for (int i = 0; i < NUM_INPUTS; i++) begin
				s.ch[i] <= CPSM_CH_POLARITY;
				s.per_cnt[i] <= CPSM_RST_PER;
				s.last_per[i] <= CPSM_RST_PER;
				s.hi_time[i] <= CPSM_RST_PER;
				s.ev_cnt[i] <= CPSM_RST_CNT;
				s.flags[i] <= CPSM_RST_FLAGS;
				s.rpt[i] <= '0;
			end
			s.invert <= '0;
			s.prev_lvl <= '0;
			s.prev_raw <= '0;
			s.prev_idx <= '0;
			s.seen_rise <= '0;
			s.seen_fall <= '0;
			s.active <= '0;
			s.st <= CPSM_ST_IDLE;
			s.abort_idx <= '0;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		event_flags = s.flags;
		event_report = s.rpt;
		polarity_inverted = s.invert;
		// One-hot codes let each status output be a bare state bit with no decode behind it.
		for (int i = 0; i < NUM_INPUTS; i++) begin
			synced[i] = s.ch[i][2];
		end
		self_test_active = s.st[1];
		self_test_aborted = s.st[2];
		abort_input = s.abort_idx;
	end
endmodule // cpsm_monitor

// File: hw/cpsm_pkg.sv
// Shared constants, encodings and carriers of the crank pickup signal monitor.
package cpsm_pkg;
	localparam int CPSM_PER_W = 24;
	localparam int CPSM_CNT_W = 12;
	localparam int CPSM_SHIFT_W = 4;
	// Positions of the per-input event flags.
	localparam int CPSM_EV_FAULTY = 0;
	localparam int CPSM_EV_LONG = 1;
	localparam int CPSM_EV_TIMEOUT = 2;
	localparam int CPSM_EV_MISMATCH = 3;
	localparam int CPSM_EV_POL_REV = 4;
	localparam int CPSM_EV_POL_FAIL = 5;
	localparam int CPSM_EV_ST_ABORT = 6;
	localparam int CPSM_EV_MARK_MISSING = 7;
	localparam int CPSM_EV_NO_INDEX = 8;
	localparam int CPSM_EV_MISSING_INDEX = 9;
	localparam int CPSM_EV_NO_SIGNAL = 10;
	localparam int CPSM_EV_SYNC_ERR = 11;
	localparam int CPSM_EV_OPER_ERR = 12;
	localparam int CPSM_EV_FAULTY_INDEX = 13;
	localparam int CPSM_EV_W = 14;
	// Reset values and the event counter limit.
	localparam logic [CPSM_PER_W-1:0] CPSM_RST_PER = 24'h000000;
	localparam logic [CPSM_CNT_W-1:0] CPSM_RST_CNT = 12'h000;
	localparam logic [CPSM_EV_W-1:0] CPSM_RST_FLAGS = 14'h0000;
	localparam logic [CPSM_CNT_W-1:0] CPSM_CNT_MAX = 12'hFFF;

	typedef enum logic [2:0] {
		CPSM_CH_POLARITY = 3'b001,
		CPSM_CH_SEARCH = 3'b010,
		CPSM_CH_SYNCED = 3'b100
	} cpsm_ch_e;

	typedef enum logic [2:0] {
		CPSM_ST_IDLE = 3'b001,
		CPSM_ST_RUN = 3'b010,
		CPSM_ST_ABORT = 3'b100
	} cpsm_st_e;

	typedef struct packed {
		logic [CPSM_PER_W-1:0] timeout;
		logic [CPSM_SHIFT_W-1:0] short_shift;
		logic [CPSM_SHIFT_W-1:0] long_shift;
		logic [CPSM_CNT_W-1:0] expected;
	} cpsm_cfg_s;

	typedef struct packed {
		logic [CPSM_PER_W-1:0] period;
		logic [CPSM_PER_W-1:0] prev_period;
		logic [CPSM_CNT_W-1:0] count;
		logic [CPSM_CNT_W-1:0] expected;
	} cpsm_rpt_s;
endpackage

// File: verif/cpsm_pickup_model.sv
// Pickup model: tooth pulses with an index mark once a turn.
`timescale 1ns/1ns
////////////////////////////////////////
module cpsm_pickup_model (
	input wire logic clock,
	input wire logic run,
	input wire logic [7:0] per,
	input wire logic [7:0] hi,
	input wire logic [3:0] teeth,
	output logic pulse = 1'b0,
	output logic idx = 1'b0
);
	int c = 0;
	int t = 0;
	int pl = 0;
	int hl = 0;
	int tl = 1;
	// A still crank gives no edges, so a stopped pickup rests low.
	always @(negedge clock) begin
		// Shape is taken only at a period boundary, so a change never cuts a tooth short.
		if (c == 0) begin
			pl = per;
			hl = hi;
			tl = teeth;
		end
		pulse <= run && c < hl;
		// The mark sits between teeth so it never shares a cycle with a tooth edge.
		idx <= run && t == 0 && c > hl && c <= hl + 2;
		c = run && c + 1 < pl ? c + 1 : 0;
		if (run && c == 0) begin
			t = (t + 1) % tl;
		end
	end
endmodule // cpsm_pickup_model

// File: verif/cpsm_monitor_asserts.sv
// Port checks of the pickup signal monitor.
`timescale 1ns/1ns
////////////////////////////////////////
module cpsm_monitor_asserts
	import cpsm_pkg::*;
#(
	parameter int NUM_INPUTS = 2,
	parameter int IDX_W = 1
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [NUM_INPUTS-1:0] engine_position_input,
	input wire cpsm_cfg_s cfg,
	input wire logic [NUM_INPUTS-1:0][CPSM_EV_W-1:0] flag_clear,
	input wire logic [NUM_INPUTS-1:0][CPSM_EV_W-1:0] event_flags,
	input wire cpsm_rpt_s [NUM_INPUTS-1:0] event_report,
	input wire logic [NUM_INPUTS-1:0] polarity_inverted,
	input wire logic [NUM_INPUTS-1:0] synced,
	input wire logic self_test_active,
	input wire logic self_test_aborted,
	input wire logic [IDX_W-1:0] abort_input
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	wire logic [CPSM_EV_W-1:0] f = event_flags[0];
	wire cpsm_rpt_s r = event_report[0];
	sequence s_disturbed;
		self_test_active && $changed(engine_position_input);
	endsequence
	property p_sticky;
		1 |=> (($past(f) & ~$past(flag_clear[0]) & ~f) == '0);
	endproperty
	property p_short;
		$rose(f[CPSM_EV_FAULTY]) |-> r.period < (r.prev_period >> cfg.short_shift);
	endproperty
	property p_long;
		$rose(f[CPSM_EV_LONG]) |-> (r.period >> cfg.long_shift) > r.prev_period;
	endproperty
	property p_mismatch;
		$rose(f[CPSM_EV_MISMATCH]) |-> r.count != r.expected;
	endproperty
	property p_resync;
		$rose(f[CPSM_EV_SYNC_ERR]) |-> ##[0:1] !synced[0];
	endproperty
	property p_pol_rev;
		$rose(polarity_inverted[1]) |-> ##[0:1] event_flags[1][CPSM_EV_POL_REV];
	endproperty
	property p_test_abort;
		s_disturbed |-> ##[1:2] self_test_aborted;
	endproperty
	property p_abort_src;
		$rose(self_test_aborted) |-> ##[0:1] event_flags[abort_input][CPSM_EV_ST_ABORT];
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag dropped");
	a_short: assert property (p_short) else $error("bad short");
	a_long: assert property (p_long) else $error("bad long");
	a_mismatch: assert property (p_mismatch) else $error("bad mismatch");
	a_resync: assert property (p_resync) else $error("still synced");
	a_pol_rev: assert property (p_pol_rev) else $error("no info flag");
	a_test_abort: assert property (p_test_abort) else $error("no abort");
	a_abort_src: assert property (p_abort_src) else $error("no abort flag");
endmodule // cpsm_monitor_asserts

// File: verif/cpsm_monitor_tb.sv
// Bench of the pickup signal monitor with two pickup models.
`timescale 1ns/1ns
////////////////////////////////////////
module cpsm_monitor_tb
	import cpsm_pkg::*;
();
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic [1:0] engine_position_input;
	logic [1:0] index_mark;
	cpsm_cfg_s cfg = '{24'h000032, 4'h1, 4'h1, 12'h004};
	logic [1:0][CPSM_EV_W-1:0] flag_clear = '0;
	logic self_test_req = 1'b0;
	logic [1:0][CPSM_EV_W-1:0] event_flags;
	cpsm_rpt_s [1:0] event_report;
	logic [1:0] polarity_inverted;
	logic [1:0] synced;
	logic self_test_active;
	logic self_test_aborted;
	logic [0:0] abort_input;
	logic [1:0] run = '0;
	logic [1:0][7:0] per = '0;
	logic [1:0][7:0] hi = '0;
	logic [1:0][3:0] teeth = 8'h44;
	int num_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	initial begin
		forever #5 clock = ~clock;
	end
	for (genvar i = 0; i < 2; i++) begin : g_pu
		cpsm_pickup_model u_pu (.clock(clock), .run(run[i]), .per(per[i]), .hi(hi[i]), .teeth(teeth[i]),
			.pulse(engine_position_input[i]), .idx(index_mark[i]));
	end
	cpsm_monitor dut (
		.clock(clock),
		.rst_b(rst_b),
		.engine_position_input(engine_position_input),
		.index_mark(index_mark),
		.cfg(cfg),
		.flag_clear(flag_clear),
		.self_test_req(self_test_req),
		.event_flags(event_flags),
		.event_report(event_report),
		.polarity_inverted(polarity_inverted),
		.synced(synced),
		.self_test_active(self_test_active),
		.self_test_aborted(self_test_aborted),
		.abort_input(abort_input)
	);
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic done(input string what, input int n);
		$display("test %s done, %0d mismatches", what, num_errors);
		repeat (n) @(negedge clock);
	endtask
	function automatic logic exp_long(input int p, input int last);
		return (p >> 1) > last;
	endfunction
	function automatic logic exp_short(input int p, input int last);
		return p < (last >> 1);
	endfunction
	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// The run is near 900 cycles, so only a hang reaches the 4000-cycle ceiling.
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			num_errors++;
			report_and_stop();
		end
	end
	initial begin
		int p0;
		int p1;
		void'($urandom(10237));
		p0 = $urandom_range(17, 10);
		p1 = $urandom_range(17, 10);
		per = {p1[7:0], p0[7:0]};
		hi = {p1[7:0] - 8'h03, 8'h02};
		repeat (3) @(negedge clock);
		rst_b = 1'b1;
		check("reset flags", event_flags, '0);
		self_test_req = 1'b1;
		done("reset", 3);
		check("test running", self_test_active, 1'b1);
		run[1] <= 1'b1;
		for (int n = 0; n < 20 && self_test_aborted !== 1'b1; n++) @(negedge clock);
		check("test aborted", self_test_aborted, 1'b1);
		check("abort input", abort_input, 1'b1);
		done("self test", 2);
		check("abort flag", event_flags[1][CPSM_EV_ST_ABORT], 1'b1);
		self_test_req = 1'b0;
		done("abort", 60);
		check("inverted", polarity_inverted[1], 1'b1);
		check("reversal flag", event_flags[1][CPSM_EV_POL_REV], 1'b1);
		check("still timeout", event_flags[0][CPSM_EV_TIMEOUT], 1'b1);
		check("timeout count", event_report[0].count, 12'h000);
		check("no signal", event_flags[0][CPSM_EV_NO_SIGNAL], 1'b1);
		check("polarity failed", event_flags[0][CPSM_EV_POL_FAIL], 1'b1);
		run[0] <= 1'b1;
		done("polarity", 200);
		check("synced", synced[0], 1'b1);
		check("no mismatch", event_flags[0][CPSM_EV_MISMATCH], 1'b0);
		per[0] <= 8'h28;
		done("sync", 150);
		check("long flag", event_flags[0][CPSM_EV_LONG], exp_long(40, p0));
		per[0] <= p0[7:0];
		done("long", 150);
		check("short flag", event_flags[0][CPSM_EV_FAULTY], exp_short(p0, 40));
		teeth[0] <= 4'h3;
		// A cut turn may first count too many teeth, so room is left for two more turns.
		done("short", 250);
		check("mismatch", event_flags[0][CPSM_EV_MISMATCH], 1'b1);
		check("sync error", event_flags[0][CPSM_EV_SYNC_ERR], 1'b1);
		check("faulty index", event_flags[0][CPSM_EV_FAULTY_INDEX], 1'b1);
		check("report expected", event_report[0].expected, 12'h004);
		check("report count", event_report[0].count, 12'h003);
		check("input 1 flags", event_flags[1], (32'h1 << CPSM_EV_ST_ABORT) | (32'h1 << CPSM_EV_POL_REV));
		flag_clear = '1;
		done("mismatch", 1);
		flag_clear = '0;
		run[0] <= 1'b0;
		done("clear", 2);
		check("cleared", event_flags[1], '0);
		check("timeout cleared", event_flags[0][CPSM_EV_TIMEOUT], 1'b0);
		done("timeout wait", 80);
		check("timeout", event_flags[0][CPSM_EV_TIMEOUT], 1'b1);
		done("timeout", 0);
		report_and_stop();
	end
endmodule // cpsm_monitor_tb
bind cpsm_monitor cpsm_monitor_asserts #(.NUM_INPUTS(NUM_INPUTS), .IDX_W(IDX_W)) u_chk (.clock(clock), .rst_b(rst_b),
	.engine_position_input(engine_position_input), .cfg(cfg), .flag_clear(flag_clear), .event_flags(event_flags),
	.event_report(event_report), .polarity_inverted(polarity_inverted), .synced(synced),
	.self_test_active(self_test_active), .self_test_aborted(self_test_aborted), .abort_input(abort_input));
